/* File: pbap_pkg.sv */
// Shared constants and types for the processor bus address port
package pbap_pkg;
  localparam int ADDR_W = 32;
  localparam int AP_W = 4;
  localparam int TT_W = 5;
  localparam int TSIZ_W = 4;
  localparam int CFG_HI_W = 8;
  localparam int EXTRA_W = 2;
  localparam int CLK_PERIOD_NS = 40;
  localparam int BUS_CLK_MAX_MHZ = 100;
  localparam int CLK_MHZ = 25;
  localparam int HARD_RESET_HOLD_NS = 1000;
  localparam int HARD_RESET_HOLD_CYC = (HARD_RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HCNT_W = 6;
  localparam logic [HCNT_W-1:0] HCNT_LOAD = HCNT_W'(HARD_RESET_HOLD_CYC);
  localparam logic [HCNT_W-1:0] HCNT_ZERO = 6'h00;
  localparam logic PIN_ASSERTED = 1'h0;
  localparam logic PIN_NEGATED = 1'h1;
  localparam int SYNC_W = 3 + 1 + ADDR_W + AP_W + TT_W + TSIZ_W;

  typedef enum logic [3:0]
  {
    PBAP_IDLE = 4'h1,
    PBAP_DECIDE = 4'h2,
    PBAP_ANSWER = 4'h4,
    PBAP_PRECHG = 4'h8
  } pbap_state_t;
endpackage : pbap_pkg

/* File: pbap_pin_if.sv */
// Raw and synchronised pin bundle between the port and its synchroniser
`timescale 1ns/1ps
interface pbap_pin_if;
  import pbap_pkg::*;
  logic [pbap_pkg::SYNC_W-1:0] raw;
  logic [pbap_pkg::SYNC_W-1:0] synced;
  modport sync_side (input raw, output synced);
  modport core_side (output raw, input synced);
endinterface : pbap_pin_if

/* File: pbap_pin_sync.sv */
// Two-flop synchroniser for every sampled bus pin
`timescale 1ns/1ps
module pbap_pin_sync
(
  input wire logic clock_i,
  input wire logic rst_i,
  pbap_pin_if.sync_side pins
);
  import pbap_pkg::*;

  logic [SYNC_W-1:0] stage1_r;
  logic [SYNC_W-1:0] stage2_r;

  // Resets to all-ones so active-low pins read negated
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      stage1_r <= '1;
      stage2_r <= '1;
    end
    else
    begin
      stage1_r <= pins.raw;
      stage2_r <= stage1_r;
    end
  end

  assign pins.synced = stage2_r;
endmodule : pbap_pin_sync

/* File: pbap_addr_port.sv */
// Device side of the processor bus address tenure
// Operation
// - All bus-facing logic runs on the single host bus clock, at most 100 MHz.
// - Power-on reset returns the whole device to its reset state.
// - Hard reset resets everything but its own output stretch; device pulses it after power-on for bus agents.
// - Device drives top eight address bits only in master configuration cycles.
// - No parity and four-channel arbiter: parity pins become extra request/grant lines.
// - Device asserts address acknowledge when it claims the address, ending the tenure.
// - Address retry rejects the transaction; master must reissue it later.
`timescale 1ns/1ps
module pbap_addr_port
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic power_on_reset_n_i,
  input wire logic hard_reset_n_i,
  output logic hard_reset_n_o,
  output logic hard_reset_n_oe_o,
  input wire logic transfer_start_n_i,
  input wire logic [0:pbap_pkg::ADDR_W-1] host_address_i,
  output logic [0:pbap_pkg::CFG_HI_W-1] host_address_hi_o,
  output logic host_address_hi_oe_o,
  input wire logic [0:pbap_pkg::AP_W-1] host_address_parity_i,
  output logic [0:pbap_pkg::AP_W-1] host_address_parity_o,
  output logic [0:pbap_pkg::AP_W-1] host_address_parity_oe_o,
  input wire logic [0:pbap_pkg::TT_W-1] transfer_type_code_i,
  input wire logic burst_indicator_n_i,
  input wire logic [0:pbap_pkg::TSIZ_W-1] transfer_byte_count_i,
  output logic address_acknowledge_n_o,
  output logic address_acknowledge_n_oe_o,
  output logic address_retry_n_o,
  output logic address_retry_n_oe_o,
  input wire logic parity_check_en_i,
  input wire logic four_channel_en_i,
  input wire logic [0:pbap_pkg::ADDR_W-1] window_base_i,
  input wire logic [0:pbap_pkg::ADDR_W-1] window_mask_i,
  input wire logic core_busy_i,
  input wire logic cfg_cycle_i,
  input wire logic [0:pbap_pkg::CFG_HI_W-1] cfg_address_hi_i,
  input wire logic [pbap_pkg::EXTRA_W-1:0] extra_bus_grant_n_i,
  input wire logic [0:pbap_pkg::AP_W-1] gpio_out_i,
  input wire logic [0:pbap_pkg::AP_W-1] gpio_oe_i,
  output logic [pbap_pkg::EXTRA_W-1:0] extra_bus_request_n_o,
  output logic [0:pbap_pkg::AP_W-1] gpio_in_o,
  output logic tenure_valid_o,
  output logic [0:pbap_pkg::ADDR_W-1] tenure_address_o,
  output logic [0:pbap_pkg::TT_W-1] tenure_type_o,
  output logic tenure_burst_o,
  output logic [0:pbap_pkg::TSIZ_W-1] tenure_size_o,
  output logic parity_error_o,
  output logic in_reset_o
);
  import pbap_pkg::*;

  function automatic logic parity_fail(input logic [0:ADDR_W-1] a, input logic [0:AP_W-1] p);
    logic bad;
    bad = 1'b0;
    // Odd parity per byte lane
    for (int i = 0; i < AP_W; i++)
      bad = bad | ~(^{a[i*8 +: 8], p[i]});
    return bad;
  endfunction : parity_fail

  pbap_pin_if pins ();

  pbap_pin_sync u_sync
  (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pins(pins.sync_side)
  );

  assign pins.raw = {power_on_reset_n_i, hard_reset_n_i, transfer_start_n_i, burst_indicator_n_i,
                     host_address_i, host_address_parity_i, transfer_type_code_i, transfer_byte_count_i};

  logic por_n_s;
  logic hres_n_s;
  logic ts_n_s;
  logic tbst_n_s;
  logic [0:ADDR_W-1] addr_s;
  logic [0:AP_W-1] ap_s;
  logic [0:TT_W-1] tt_s;
  logic [0:TSIZ_W-1] tsiz_s;
  assign {por_n_s, hres_n_s, ts_n_s, tbst_n_s, addr_s, ap_s, tt_s, tsiz_s} = pins.synced;

  logic por_rst;
  logic dev_rst;
  assign por_rst = rst_i | (por_n_s == PIN_ASSERTED);
  assign dev_rst = por_rst | (hres_n_s == PIN_ASSERTED);

  // Hard reset output stretch; only power-on or rst_i can reset it, so it cannot lock itself
  logic [HCNT_W-1:0] hcnt_r;
  always_ff @(posedge clock_i)
  begin
    if (por_rst)
    begin
      hcnt_r <= HCNT_LOAD;
      hard_reset_n_o <= PIN_ASSERTED;
      hard_reset_n_oe_o <= 1'b1;
    end
    else
    begin
      if (hcnt_r != HCNT_ZERO)
        hcnt_r <= hcnt_r - 6'h01;
      hard_reset_n_o <= (hcnt_r > 6'h01) ? PIN_ASSERTED : PIN_NEGATED;
      hard_reset_n_oe_o <= (hcnt_r != HCNT_ZERO);
    end
  end

  always_ff @(posedge clock_i)
  begin
    in_reset_o <= dev_rst;
  end

  pbap_state_t state_r;
  logic [0:ADDR_W-1] addr_r;
  logic [0:TT_W-1] tt_r;
  logic burst_r;
  logic [0:TSIZ_W-1] tsiz_r;
  logic perr_r;
  logic retry_r;
  logic hit;
  assign hit = ((addr_r ^ window_base_i) & window_mask_i) == '0;

  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      state_r <= PBAP_IDLE;
      addr_r <= '0;
      tt_r <= '0;
      burst_r <= 1'b0;
      tsiz_r <= '0;
      perr_r <= 1'b0;
      retry_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        PBAP_IDLE:
        begin
          if (ts_n_s == PIN_ASSERTED)
          begin
            addr_r <= addr_s;
            tt_r <= tt_s;
            burst_r <= (tbst_n_s == PIN_ASSERTED);
            tsiz_r <= tsiz_s;
            perr_r <= parity_check_en_i & parity_fail(addr_s, ap_s);
            state_r <= PBAP_DECIDE;
          end
        end
        PBAP_DECIDE:
        begin
          // Unclaimed addresses get no answer so another slave may claim them
          retry_r <= perr_r | core_busy_i;
          state_r <= hit ? PBAP_ANSWER : PBAP_IDLE;
        end
        PBAP_ANSWER:
          state_r <= PBAP_PRECHG;
        PBAP_PRECHG:
          state_r <= PBAP_IDLE;
      endcase
    end
  end

  // Answer pins: one cycle asserted (retry only when retrying), then one cycle driven negated before release
  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      address_acknowledge_n_o <= PIN_NEGATED;
      address_acknowledge_n_oe_o <= 1'b0;
      address_retry_n_o <= PIN_NEGATED;
      address_retry_n_oe_o <= 1'b0;
    end
    else
    begin
      address_acknowledge_n_o <= (state_r == PBAP_DECIDE && hit) ? PIN_ASSERTED : PIN_NEGATED;
      address_acknowledge_n_oe_o <= (state_r == PBAP_DECIDE && hit) || state_r == PBAP_ANSWER;
      address_retry_n_o <= (state_r == PBAP_DECIDE && hit && (perr_r | core_busy_i))
                           ? PIN_ASSERTED : PIN_NEGATED;
      address_retry_n_oe_o <= (state_r == PBAP_DECIDE && hit) || state_r == PBAP_ANSWER;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      tenure_valid_o <= 1'b0;
      tenure_address_o <= '0;
      tenure_type_o <= '0;
      tenure_burst_o <= 1'b0;
      tenure_size_o <= '0;
      parity_error_o <= 1'b0;
    end
    else
    begin
      // Retried tenures never reach the core
      tenure_valid_o <= (state_r == PBAP_ANSWER) && !retry_r;
      tenure_address_o <= addr_r;
      tenure_type_o <= tt_r;
      tenure_burst_o <= burst_r;
      tenure_size_o <= tsiz_r;
      parity_error_o <= (state_r == PBAP_ANSWER) && perr_r;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      host_address_hi_o <= '0;
      host_address_hi_oe_o <= 1'b0;
    end
    else
    begin
      host_address_hi_o <= cfg_address_hi_i;
      host_address_hi_oe_o <= cfg_cycle_i;
    end
  end

  logic extra_mode;
  assign extra_mode = four_channel_en_i & ~parity_check_en_i;

  // Parity pins 0..1 carry requests in, 2..3 carry grants out in extra mode
  always_ff @(posedge clock_i)
  begin
    if (dev_rst)
    begin
      host_address_parity_o <= '1;
      host_address_parity_oe_o <= '0;
      extra_bus_request_n_o <= '1;
      gpio_in_o <= '0;
    end
    else if (extra_mode)
    begin
      host_address_parity_o <= {2'h3, extra_bus_grant_n_i};
      host_address_parity_oe_o <= 4'h3;
      extra_bus_request_n_o <= ap_s[0:1];
      gpio_in_o <= '0;
    end
    else
    begin
      host_address_parity_o <= gpio_out_i;
      host_address_parity_oe_o <= parity_check_en_i ? 4'h0 : gpio_oe_i;
      extra_bus_request_n_o <= '1;
      gpio_in_o <= ap_s;
    end
  end

  logic [1:0] ack_cnt_r;
  always_ff @(posedge clock_i)
  begin
    if (dev_rst || state_r == PBAP_IDLE)
      ack_cnt_r <= 2'h0;
    else if (address_acknowledge_n_o == PIN_ASSERTED)
      ack_cnt_r <= ack_cnt_r + 2'h1;
  end

  property one_ack_p;
    @(posedge clock_i) disable iff (dev_rst)
      ack_cnt_r <= 2'h1;
  endproperty

  ack_once_a: assert property (one_ack_p) else $error("more than one acknowledge per tenure");
  ack_timing_a: assert property (@(posedge clock_i) disable iff (dev_rst)
    state_r == PBAP_DECIDE && hit |=> address_acknowledge_n_o == PIN_ASSERTED && address_acknowledge_n_oe_o
    ##1 address_acknowledge_n_o == PIN_NEGATED && address_acknowledge_n_oe_o)
    else $error("acknowledge not one cycle after claim");
  retry_with_ack_a: assert property (@(posedge clock_i) disable iff (dev_rst)
    address_retry_n_o == PIN_ASSERTED |-> address_acknowledge_n_o == PIN_ASSERTED ##1 !tenure_valid_o)
    else $error("retry without acknowledge or with delivery");
  parity_retry_a: assert property (@(posedge clock_i) disable iff (dev_rst)
    state_r == PBAP_DECIDE && hit && perr_r |=> address_retry_n_o == PIN_ASSERTED)
    else $error("parity error not retried");
  ts_capture_a: assert property (@(posedge clock_i) disable iff (dev_rst)
    state_r == PBAP_IDLE && ts_n_s == PIN_ASSERTED |=> state_r == PBAP_DECIDE && addr_r == $past(addr_s))
    else $error("transfer start not captured");
  cfg_drive_a: assert property (@(posedge clock_i) disable iff (dev_rst)
    host_address_hi_oe_o |-> $past(cfg_cycle_i))
    else $error("upper address driven outside config cycle");
  por_reset_a: assert property (@(posedge clock_i)
    por_rst |=> state_r == PBAP_IDLE && !address_acknowledge_n_oe_o && hard_reset_n_oe_o)
    else $error("power-on reset did not clear state");
  hres_reset_a: assert property (@(posedge clock_i)
    hres_n_s == PIN_ASSERTED |=> state_r == PBAP_IDLE && !tenure_valid_o && in_reset_o)
    else $error("hard reset did not clear state");
  extra_pins_a: assert property (@(posedge clock_i) disable iff (dev_rst)
    extra_mode ##1 extra_mode |-> host_address_parity_oe_o == 4'h3
    && host_address_parity_o[2:3] == $past(extra_bus_grant_n_i))
    else $error("parity pins not serving as grant lines");
  active_low_a: assert property (@(posedge clock_i) disable iff (dev_rst)
    tenure_valid_o |-> $past(address_acknowledge_n_o == 1'b0 && address_retry_n_o == 1'b1))
    else $error("delivered tenure without low acknowledge");
  one_clock_a: assert property (@(posedge clock_i) disable iff (dev_rst)
    state_r == PBAP_ANSWER |=> state_r == PBAP_PRECHG ##1 state_r == PBAP_IDLE)
    else $error("answer sequence not clocked as expected");

  accept_c: cover property (@(posedge clock_i) disable iff (dev_rst) tenure_valid_o && tenure_burst_o);
  retry_c: cover property (@(posedge clock_i) disable iff (dev_rst) address_retry_n_o == PIN_ASSERTED);
  miss_c: cover property (@(posedge clock_i) disable iff (dev_rst) state_r == PBAP_DECIDE && !hit);
  cfg_c: cover property (@(posedge clock_i) disable iff (dev_rst) host_address_hi_oe_o);
endmodule : pbap_addr_port

/* File: pbap_host_model.sv */
// Bus master model that opens address tenures toward the port
`timescale 1ns/1ps
module pbap_host_model
(
  input wire logic clock_i,
  input wire logic address_acknowledge_n_i,
  input wire logic address_acknowledge_n_oe_i,
  input wire logic address_retry_n_i,
  output logic transfer_start_n_o,
  output logic [0:31] host_address_o,
  output logic [0:3] host_address_parity_o,
  output logic [0:4] transfer_type_code_o,
  output logic burst_indicator_n_o,
  output logic [0:3] transfer_byte_count_o
);
  initial
  begin
    transfer_start_n_o = 1'b1;
    host_address_o = 32'h0;
    host_address_parity_o = 4'h0;
    transfer_type_code_o = 5'h0;
    burst_indicator_n_o = 1'b1;
    transfer_byte_count_o = 4'h0;
  end

  task automatic set_pins(input logic [0:3] v);
    host_address_parity_o = v;
  endtask : set_pins

  // Pins change on a falling edge or 1 ns after a rising edge, never on a rising edge
  task automatic issue(input logic [0:31] a, input logic [0:4] tt, input logic bst, input logic [0:3] sz,
    input logic bad_par, output logic acked, output logic retried);
    acked = 1'b0;
    retried = 1'b0;
    @(negedge clock_i);
    transfer_start_n_o = 1'b0;
    host_address_o = a;
    for (int i = 0; i < 4; i++)
    begin
      host_address_parity_o[i] = ~^a[8*i +: 8];
    end
    host_address_parity_o[0] = host_address_parity_o[0] ^ bad_par;
    transfer_type_code_o = tt;
    burst_indicator_n_o = ~bst;
    transfer_byte_count_o = sz;
    @(negedge clock_i);
    transfer_start_n_o = 1'b1;
    for (int n = 0; n < 12 && !acked; n++)
    begin
      @(posedge clock_i);
      #1;
      if (address_acknowledge_n_oe_i === 1'b1 && address_acknowledge_n_i === 1'b0)
      begin
        acked = 1'b1;
        retried = ~address_retry_n_i;
      end
    end
    // Released address, parity, type and size lines show the inverse so stale values never pass
    host_address_o = ~host_address_o;
    host_address_parity_o = ~host_address_parity_o;
    transfer_type_code_o = ~transfer_type_code_o;
    transfer_byte_count_o = ~transfer_byte_count_o;
    burst_indicator_n_o = 1'b1;
  endtask : issue
endmodule : pbap_host_model

/* File: processor_bus_address_port_tb.sv */
// Self-checking bench for the processor bus address port
`timescale 1ns/1ps
module processor_bus_address_port_tb;
  import pbap_pkg::*;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic por_n = 1'b1, pe = 1'b0, fc = 1'b0, busy = 1'b0, cfg = 1'b0;
  logic [0:7] cfg_hi = 8'h00;
  logic [1:0] gnt_n = 2'h3;
  logic [0:3] gout = 4'h0, goe = 4'h0, hap, ap_o, ap_oe, gin;
  logic ts_n, bst_n, hr_o, hr_oe, hi_oe, ack_n, ack_oe, rty_n, rty_oe, tv, tbst, perr, inr, ok, rt;
  logic [0:31] addr, ta;
  logic [0:4] tt, ttp;
  logic [0:3] tsz, tsize;
  logic [0:7] hi;
  logic [1:0] req_n;
  int err_total = 0;
  int samples_checked = 0;
  wire hr_pin = hr_oe ? hr_o : 1'b1;
  wire [0:3] ap_pin = (ap_oe & ap_o) | (~ap_oe & hap);

  always #(CLK_PERIOD_NS / 2) clock_i = ~clock_i;

  pbap_host_model u_host (.clock_i(clock_i), .address_acknowledge_n_i(ack_n), .address_acknowledge_n_oe_i(ack_oe),
    .address_retry_n_i(rty_n), .transfer_start_n_o(ts_n), .host_address_o(addr), .host_address_parity_o(hap),
    .transfer_type_code_o(tt), .burst_indicator_n_o(bst_n), .transfer_byte_count_o(tsz));

  pbap_addr_port u_dut (.clock_i(clock_i), .rst_i(rst_i), .power_on_reset_n_i(por_n), .hard_reset_n_i(hr_pin),
    .hard_reset_n_o(hr_o), .hard_reset_n_oe_o(hr_oe), .transfer_start_n_i(ts_n), .host_address_i(addr),
    .host_address_hi_o(hi), .host_address_hi_oe_o(hi_oe), .host_address_parity_i(ap_pin),
    .host_address_parity_o(ap_o), .host_address_parity_oe_o(ap_oe), .transfer_type_code_i(tt),
    .burst_indicator_n_i(bst_n), .transfer_byte_count_i(tsz), .address_acknowledge_n_o(ack_n),
    .address_acknowledge_n_oe_o(ack_oe), .address_retry_n_o(rty_n), .address_retry_n_oe_o(rty_oe),
    .parity_check_en_i(pe), .four_channel_en_i(fc), .window_base_i(32'h1000_0000),
    .window_mask_i(32'hf000_0000), .core_busy_i(busy), .cfg_cycle_i(cfg), .cfg_address_hi_i(cfg_hi),
    .extra_bus_grant_n_i(gnt_n), .gpio_out_i(gout), .gpio_oe_i(goe), .extra_bus_request_n_o(req_n),
    .gpio_in_o(gin), .tenure_valid_o(tv), .tenure_address_o(ta), .tenure_type_o(ttp),
    .tenure_burst_o(tbst), .tenure_size_o(tsize), .parity_error_o(perr), .in_reset_o(inr));

  // Wide enough for the whole captured tenure record
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick

  // Own hard reset pulse must finish before the first tenure
  task automatic wait_free();
    int n;
    for (n = 0; n < 200 && hr_oe !== 1'b0; n++)
      tick(1);
    if (n == 200)
    begin
      err_total++;
      close_out();
    end
    tick(3);
  endtask : wait_free

  task automatic t_reset();
    chk(ack_oe, 0, "ack driven in reset");
    chk({hr_oe, hr_o}, 2'b10, "hard reset not driven");
    chk(inr, 1, "in reset flag");
    rst_i = 1'b0;
    wait_free();
    chk(inr, 0, "still in reset");
    $display("reset test done");
  endtask : t_reset

  task automatic t_claim(input logic [0:31] a, input logic [0:4] c, input logic b, input logic [0:3] s);
    u_host.issue(a, c, b, s, 1'b0, ok, rt);
    chk({ok, rt}, 2'b10, "claim answer");
    tick(1);
    chk({tv, perr, ta, ttp, tbst, tsize}, {2'b10, a, c, b, s}, "tenure fields");
    chk(ack_n, 1, "ack longer than a cycle");
    tick(1);
    chk(tv, 0, "tenure pulse length");
    $display("claim test done");
  endtask : t_claim

  task automatic t_unclaimed();
    u_host.issue(32'h2000_0000, 5'h02, 1'b0, 4'h1, 1'b0, ok, rt);
    chk(ok, 0, "answer to foreign address");
    $display("unclaimed test done");
  endtask : t_unclaimed

  task automatic t_retry();
    @(negedge clock_i);
    busy = 1'b1;
    u_host.issue(32'h1abc_0000, 5'h0e, 1'b1, 4'h0, 1'b0, ok, rt);
    chk({ok, rt, rty_oe}, 3'b111, "retry when busy");
    @(negedge clock_i);
    busy = 1'b0;
    tick(1);
    chk(tv, 0, "retried tenure accepted");
    u_host.issue(32'h1abc_0000, 5'h0e, 1'b1, 4'h0, 1'b0, ok, rt);
    chk({ok, rt}, 2'b10, "reissue refused");
    $display("retry test done");
  endtask : t_retry

  task automatic t_parity();
    @(negedge clock_i);
    pe = 1'b1;
    t_claim(32'h1f0f_5a3c, 5'h08, 1'b0, 4'h8);
    u_host.issue(32'h1f0f_5a3c, 5'h08, 1'b0, 4'h8, 1'b1, ok, rt);
    chk({ok, rt}, 2'b11, "bad parity answer");
    tick(1);
    chk({perr, tv}, 2'b10, "parity error flag");
    @(negedge clock_i);
    pe = 1'b0;
    $display("parity test done");
  endtask : t_parity

  task automatic t_cfg();
    chk(hi_oe, 0, "high address driven idle");
    @(negedge clock_i);
    cfg = 1'b1;
    cfg_hi = 8'ha5;
    tick(1);
    chk({hi_oe, hi}, 9'h1a5, "config drive");
    @(negedge clock_i);
    cfg = 1'b0;
    tick(1);
    chk(hi_oe, 0, "config drive held");
    $display("config test done");
  endtask : t_cfg

  task automatic t_extra();
    @(negedge clock_i);
    goe = 4'hf;
    gout = 4'h5;
    tick(4);
    chk({ap_oe, ap_o}, 8'hf5, "gpio drive");
    chk(gin, 4'h5, "gpio input");
    @(negedge clock_i);
    fc = 1'b1;
    gnt_n = 2'b10;
    u_host.set_pins(4'b0100);
    tick(4);
    chk({ap_oe[2:3], ap_o[2:3], req_n}, 6'b111001, "extra arbiter lines");
    chk(ap_oe[0:1], 0, "request pins driven");
    @(negedge clock_i);
    pe = 1'b1;
    tick(4);
    chk(req_n, 2'b11, "requests with parity on");
    @(negedge clock_i);
    pe = 1'b0;
    fc = 1'b0;
    goe = 4'h0;
    $display("extra lines test done");
  endtask : t_extra

  task automatic t_por();
    @(negedge clock_i);
    por_n = 1'b0;
    tick(4);
    chk({inr, hr_oe, hr_o, ack_oe}, 4'b1100, "power-on reset effect");
    @(negedge clock_i);
    por_n = 1'b1;
    wait_free();
    t_claim(32'h1000_0004, 5'h0a, 1'b0, 4'h4);
    $display("power-on test done");
  endtask : t_por

  initial
  begin
    repeat (12) @(posedge clock_i);
    @(negedge clock_i);
    t_reset();
    t_claim(32'h1234_5678, 5'h0a, 1'b0, 4'h2);
    t_claim(32'h1fff_fff0, 5'h1f, 1'b1, 4'h0);
    t_unclaimed();
    t_retry();
    t_parity();
    t_cfg();
    t_extra();
    t_por();
    close_out();
  end
endmodule : processor_bus_address_port_tb
